//--- logic/fcd_pkg.sv
// package of command codes, addresses and timing for the flash command host
package fcd_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam logic [10:0] UNLOCK_A1 = 11'h555;
    localparam logic [10:0] UNLOCK_A2 = 11'h2AA;
    localparam logic [7:0] UNLOCK_D1 = 8'hAA;
    localparam logic [7:0] UNLOCK_D2 = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_PROG = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [17:0] ID_MFR_ADDR = 18'h00000;
    localparam logic [17:0] ID_DEV_ADDR = 18'h00001;
    localparam logic [17:0] ID_PROT_ADDR = 18'h00002;
    localparam int SECTOR_LSB = 13;
    localparam int HIGH_LSB = 11;
    localparam int DATA_TOP = 7;
    // strobe phase lengths in ns, converted to cycles at 5 ns
    localparam int CLK_NS = 5;
    localparam int SETUP_NS = 20;
    localparam int PULSE_NS = 40;
    localparam int HOLD_NS = 20;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] OP_RESET1 = 4'h0;
    localparam logic [3:0] OP_RESET3 = 4'h1;
    localparam logic [3:0] OP_IDENT = 4'h2;
    localparam logic [3:0] OP_PROG = 4'h3;
    localparam logic [3:0] OP_CHIP_ERASE = 4'h4;
    localparam logic [3:0] OP_SECTOR_ERASE = 4'h5;
    localparam logic [3:0] OP_SUSPEND = 4'h6;
    localparam logic [3:0] OP_RESUME = 4'h7;
    localparam logic [3:0] OP_READ = 4'h8;
    localparam logic [3:0] OP_READ_ID = 4'h9;
    localparam logic [3:0] OP_READ_PROT = 4'hA;
    localparam logic [3:0] OP_HV_ON = 4'hB;
    localparam logic [3:0] OP_HV_OFF = 4'hC;
    localparam logic [2:0] STEP_LAST_MAX = 3'h5;
endpackage

//--- logic/fcd_bus_cycle.sv
// one parallel bus cycle: write or read strobe timing with registered pins
`timescale 1ns/1ps
module fcd_bus_cycle #(
    parameter int SETUP = fcd_pkg::SETUP_CYC,
    parameter int PULSE = fcd_pkg::PULSE_CYC,
    parameter int HOLD = fcd_pkg::HOLD_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // request
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [17:0] i_addr,
    input wire logic [7:0] i_data,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_rdata,
    // flash pins
    output logic [17:0] o_addr,
    output logic [7:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [7:0] i_dq_in,
    output logic o_ce_n,
    output logic o_we_n,
    output logic o_oe_n
);
    typedef enum logic [1:0] {
        FCD_IDLE = 2'b00,
        FCD_SETUP = 2'b01,
        FCD_PULSE = 2'b10,
        FCD_HOLD = 2'b11
    } fcd_bus_state_t;

    fcd_bus_state_t st_q, st_d;
    logic [7:0] cnt_q, cnt_d;
    logic wr_q, wr_d;
    logic [17:0] addr_q, addr_d;
    logic [7:0] dout_q, dout_d;
    logic [7:0] rdata_q, rdata_d;
    logic done_q, done_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        addr_d = addr_q;
        dout_d = dout_q;
        rdata_d = rdata_q;
        done_d = 1'b0;
        unique case (st_q)
            FCD_IDLE: begin
                if (i_start) begin
                    // address is stable before the strobe falls
                    st_d = FCD_SETUP;
                    wr_d = i_write;
                    addr_d = i_addr;
                    dout_d = i_data;
                    cnt_d = 8'(SETUP);
                end
            end
            FCD_SETUP: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    st_d = FCD_PULSE;
                    cnt_d = 8'(PULSE);
                end
            end
            FCD_PULSE: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    st_d = FCD_HOLD;
                    cnt_d = 8'(HOLD);
                    if (!wr_q) begin
                        rdata_d = i_dq_in;
                    end
                end
            end
            FCD_HOLD: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    st_d = FCD_IDLE;
                    done_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            st_q <= FCD_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            addr_q <= 18'h00000;
            dout_q <= 8'h00;
            rdata_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            dout_q <= dout_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins: ce and we low with oe high for a write; data held over rising edge
    logic ce_n_q, we_n_q, oe_n_q, dq_oe_q;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ce_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            dq_oe_q <= 1'b0;
        end else begin
            ce_n_q <= (st_d == FCD_IDLE);
            we_n_q <= !(st_d == FCD_PULSE && wr_d);
            oe_n_q <= !(st_d == FCD_PULSE && !wr_d);
            dq_oe_q <= (st_d != FCD_IDLE) && wr_d;
        end
    end

    assign o_addr = addr_q;
    assign o_dq_out = dout_q;
    assign o_dq_oe = dq_oe_q;
    assign o_ce_n = ce_n_q;
    assign o_we_n = we_n_q;
    assign o_oe_n = oe_n_q;
    assign o_rdata = rdata_q;
    assign o_done = done_q;
    assign o_busy = (st_q != FCD_IDLE);

    strobe_excl_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !(!o_we_n && !o_oe_n)) else $error("we and oe low together");
    we_inside_ce_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !o_we_n |-> !o_ce_n && o_dq_oe) else $error("we low without ce");
    addr_stable_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !o_we_n && !$past(o_we_n) |-> $stable(o_addr) && $stable(o_dq_out))
        else $error("address moved in strobe");
endmodule

//--- logic/fcd_host.sv
// host controller that issues command sequences to the flash command decoder
`timescale 1ns/1ps
module fcd_host #(
    parameter int SETUP = fcd_pkg::SETUP_CYC,
    parameter int PULSE = fcd_pkg::PULSE_CYC,
    parameter int HOLD = fcd_pkg::HOLD_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // user command port
    input wire logic i_req,
    input wire logic [3:0] i_op,
    input wire logic [17:0] i_addr,
    input wire logic [7:0] i_data,
    output logic o_ready,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_parity_ok,
    output logic o_in_ident,
    output logic o_erasing,
    // flash pins
    output logic [17:0] o_flash_addr,
    output logic [7:0] o_flash_dq_out,
    output logic o_flash_dq_oe,
    input wire logic [7:0] i_flash_dq_in,
    output logic o_flash_ce_n,
    output logic o_flash_we_n,
    output logic o_flash_oe_n,
    output logic o_flash_reset_hv
);
    typedef enum logic [1:0] {
        FCD_H_IDLE = 2'b00,
        FCD_H_ISSUE = 2'b01,
        FCD_H_WAIT = 2'b10,
        FCD_H_FINISH = 2'b11
    } fcd_host_state_t;

    fcd_host_state_t st_q, st_d;
    logic [3:0] op_q, op_d;
    logic [17:0] uaddr_q, uaddr_d;
    logic [7:0] udata_q, udata_d;
    logic [2:0] step_q, step_d;
    logic [2:0] last_q, last_d;
    logic ident_q, ident_d;
    logic erasing_q, erasing_d;
    logic hv_q, hv_d;
    logic done_q, done_d;
    logic par_q, par_d;
    logic [7:0] rdata_q, rdata_d;
    logic ready_q;
    logic bus_start;
    logic bus_write;
    logic [17:0] bus_addr;
    logic [7:0] bus_data;
    logic bus_busy;
    logic bus_done;
    logic [7:0] bus_rdata;

    ////////////////////////////////////////////////////////////////////////
    // step table: address and data of write number step for the current op
    always_comb begin
        bus_write = 1'b1;
        bus_addr = {7'h00, fcd_pkg::UNLOCK_A1}; // high bits zero: don't care
        bus_data = fcd_pkg::UNLOCK_D1;
        if (step_q == 3'h1 || step_q == 3'h4) begin
            bus_addr = {7'h00, fcd_pkg::UNLOCK_A2};
            bus_data = fcd_pkg::UNLOCK_D2;
        end
        unique case (op_q)
            fcd_pkg::OP_RESET1, fcd_pkg::OP_SUSPEND, fcd_pkg::OP_RESUME: begin
                bus_addr = uaddr_q; // any address
                bus_data = (op_q == fcd_pkg::OP_RESET1) ? fcd_pkg::CMD_RESET :
                    (op_q == fcd_pkg::OP_SUSPEND) ? fcd_pkg::CMD_SUSPEND :
                    fcd_pkg::CMD_RESUME;
            end
            fcd_pkg::OP_RESET3: begin
                if (step_q == 3'h2) bus_data = fcd_pkg::CMD_RESET;
            end
            fcd_pkg::OP_IDENT: begin
                if (step_q == 3'h2) bus_data = fcd_pkg::CMD_IDENT;
            end
            fcd_pkg::OP_PROG: begin
                if (step_q == 3'h2) bus_data = fcd_pkg::CMD_PROG;
                if (step_q == 3'h3) begin
                    bus_addr = uaddr_q;
                    bus_data = udata_q;
                end
            end
            fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_SECTOR_ERASE: begin
                if (step_q == 3'h2) bus_data = fcd_pkg::CMD_ERASE_SETUP;
                if (step_q == 3'h5) begin
                    if (op_q == fcd_pkg::OP_CHIP_ERASE) begin
                        bus_data = fcd_pkg::CMD_CHIP_ERASE;
                    end else begin
                        bus_addr = uaddr_q; // sector picked by top five bits
                        bus_data = fcd_pkg::CMD_SECTOR_ERASE;
                    end
                end
            end
            fcd_pkg::OP_READ, fcd_pkg::OP_READ_PROT: begin
                bus_write = 1'b0;
                bus_addr = uaddr_q;
                if (op_q == fcd_pkg::OP_READ_PROT) begin
                    // bits 10,6,1,0 = 0,0,1,0 with sector bits on top
                    bus_addr = {uaddr_q[17:fcd_pkg::SECTOR_LSB],
                        fcd_pkg::ID_PROT_ADDR[fcd_pkg::SECTOR_LSB-1:0]};
                end
            end
            fcd_pkg::OP_READ_ID: begin
                bus_write = 1'b0;
                bus_addr = uaddr_q[0] ? fcd_pkg::ID_DEV_ADDR : fcd_pkg::ID_MFR_ADDR;
            end
            default: begin
                bus_write = 1'b0;
            end
        endcase
    end

    // number of the last write for each op
    function automatic logic [2:0] fcd_last(input logic [3:0] op);
        logic [2:0] n;
        n = 3'h0;
        if (op == fcd_pkg::OP_RESET3 || op == fcd_pkg::OP_IDENT) n = 3'h2;
        if (op == fcd_pkg::OP_PROG) n = 3'h3;
        if (op == fcd_pkg::OP_CHIP_ERASE || op == fcd_pkg::OP_SECTOR_ERASE) begin
            n = fcd_pkg::STEP_LAST_MAX;
        end
        return n;
    endfunction

    // requests that would break the documented order are refused
    function automatic logic fcd_legal(input logic [3:0] op, input logic id,
        input logic er);
        logic ok;
        ok = 1'b1;
        if ((op == fcd_pkg::OP_SUSPEND || op == fcd_pkg::OP_RESUME) && !er) ok = 1'b0;
        if (op == fcd_pkg::OP_IDENT && id) ok = 1'b0;
        if (op == fcd_pkg::OP_READ_ID && !id) ok = 1'b0;
        if (op > fcd_pkg::OP_HV_OFF) ok = 1'b0;
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        uaddr_d = uaddr_q;
        udata_d = udata_q;
        step_d = step_q;
        last_d = last_q;
        ident_d = ident_q;
        erasing_d = erasing_q;
        hv_d = hv_q;
        done_d = 1'b0;
        par_d = par_q;
        rdata_d = rdata_q;
        bus_start = 1'b0;
        unique case (st_q)
            FCD_H_IDLE: begin
                // requests are taken only while ready is shown to the user
                if (i_req && ready_q && fcd_legal(i_op, ident_q, erasing_q)) begin
                    op_d = i_op;
                    uaddr_d = i_addr;
                    udata_d = i_data;
                    step_d = 3'h0;
                    last_d = fcd_last(i_op);
                    st_d = FCD_H_ISSUE;
                    if (i_op == fcd_pkg::OP_HV_ON || i_op == fcd_pkg::OP_HV_OFF) begin
                        hv_d = (i_op == fcd_pkg::OP_HV_ON);
                        st_d = FCD_H_FINISH;
                    end
                end else if (i_req && ready_q) begin
                    done_d = 1'b1;
                end
            end
            FCD_H_ISSUE: begin
                bus_start = 1'b1; // one bus cycle per step
                st_d = FCD_H_WAIT;
            end
            FCD_H_WAIT: begin
                if (bus_done) begin
                    if (step_q == last_q) begin
                        st_d = FCD_H_FINISH;
                        rdata_d = bus_rdata;
                        par_d = ^bus_rdata; // odd parity over all eight bits
                    end else begin
                        step_d = step_q + 3'h1;
                        st_d = FCD_H_ISSUE;
                    end
                end
            end
            FCD_H_FINISH: begin
                done_d = 1'b1;
                st_d = FCD_H_IDLE;
                if (op_q == fcd_pkg::OP_RESET1 || op_q == fcd_pkg::OP_RESET3) begin
                    ident_d = 1'b0; // back to read mode
                    erasing_d = 1'b0;
                end
                if (op_q == fcd_pkg::OP_IDENT) ident_d = 1'b1;
                if (op_q == fcd_pkg::OP_SECTOR_ERASE) erasing_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            st_q <= FCD_H_IDLE;
            op_q <= fcd_pkg::OP_READ;
            uaddr_q <= 18'h00000;
            udata_q <= 8'h00;
            step_q <= 3'h0;
            last_q <= 3'h0;
            ident_q <= 1'b0; // device assumed in read mode
            erasing_q <= 1'b0;
            hv_q <= 1'b0;
            done_q <= 1'b0;
            par_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            uaddr_q <= uaddr_d;
            udata_q <= udata_d;
            step_q <= step_d;
            last_q <= last_d;
            ident_q <= ident_d;
            erasing_q <= erasing_d;
            hv_q <= hv_d;
            done_q <= done_d;
            par_q <= par_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    fcd_bus_cycle #(
        .SETUP(SETUP),
        .PULSE(PULSE),
        .HOLD(HOLD)
    ) u_bus (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_start(bus_start),
        .i_write(bus_write),
        .i_addr(bus_addr),
        .i_data(bus_data),
        .o_busy(bus_busy),
        .o_done(bus_done),
        .o_rdata(bus_rdata),
        .o_addr(o_flash_addr),
        .o_dq_out(o_flash_dq_out),
        .o_dq_oe(o_flash_dq_oe),
        .i_dq_in(i_flash_dq_in),
        .o_ce_n(o_flash_ce_n),
        .o_we_n(o_flash_we_n),
        .o_oe_n(o_flash_oe_n)
    );

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= (st_d == FCD_H_IDLE) && !done_d;
        end
    end

    assign o_ready = ready_q;
    assign o_done = done_q;
    assign o_rdata = rdata_q;
    assign o_parity_ok = par_q;
    assign o_in_ident = ident_q;
    assign o_erasing = erasing_q;
    assign o_flash_reset_hv = hv_q;

    ////////////////////////////////////////////////////////////////////////
    reset_code_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == FCD_H_ISSUE && op_q == fcd_pkg::OP_RESET1 |-> bus_data == fcd_pkg::CMD_RESET)
        else $error("single reset without reset code");
    prog_last_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == FCD_H_ISSUE && op_q == fcd_pkg::OP_PROG && step_q == 3'h3
        |-> bus_addr == uaddr_q && bus_data == udata_q)
        else $error("program final cycle wrong");
    unlock_first_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == FCD_H_ISSUE && step_q == 3'h0 && last_q != 3'h0
        |-> bus_addr[10:0] == fcd_pkg::UNLOCK_A1 && bus_data == fcd_pkg::UNLOCK_D1)
        else $error("first unlock wrong");
    suspend_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == FCD_H_ISSUE && op_q == fcd_pkg::OP_SUSPEND |-> erasing_q)
        else $error("suspend outside sector erase");
    ident_reset_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == FCD_H_IDLE && o_ready && i_req && i_op == fcd_pkg::OP_IDENT && ident_q
        |=> st_q == FCD_H_IDLE && o_done) else $error("identify not refused");
    one_step_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        bus_start |=> bus_busy ##1 !bus_start) else $error("double start");
    hv_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_flash_reset_hv && st_q == FCD_H_WAIT |=> o_flash_reset_hv)
        else $error("high voltage dropped mid command");
    prot_addr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == FCD_H_ISSUE && op_q == fcd_pkg::OP_READ_PROT
        |-> bus_addr[1:0] == 2'b10 && !bus_addr[6] && !bus_addr[10])
        else $error("protect read address wrong");
    sector_last_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == FCD_H_ISSUE && op_q == fcd_pkg::OP_SECTOR_ERASE && step_q == 3'h5
        |-> bus_data == fcd_pkg::CMD_SECTOR_ERASE && bus_addr == uaddr_q)
        else $error("sector erase last cycle wrong");
    prog_cov_c: cover property (@(posedge i_clk) op_q == fcd_pkg::OP_PROG && o_done);
    serase_cov_c: cover property (@(posedge i_clk) op_q == fcd_pkg::OP_SECTOR_ERASE && o_done);
    ident_cov_c: cover property (@(posedge i_clk) op_q == fcd_pkg::OP_READ_ID && o_done);
endmodule

//--- dv/fcd_flash_model.sv
// behavioural flash device that answers the host's bus cycles
`timescale 1ns/1ps
module fcd_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h01, // arbitrary value, odd parity
    parameter logic [7:0] DEV_CODE = 8'h07, // arbitrary value, odd parity
    parameter logic [4:0] PROT_SECT = 5'h03
) (
    input wire logic [17:0] i_addr,
    input wire logic [7:0] i_dq,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic i_reset_hv,
    output logic [7:0] o_dq
);
    logic [7:0] mem [0:262143];
    logic [2:0] st = 3'h0;
    logic ident = 1'h0;
    logic erasing = 1'h0;
    logic chip;
    logic [17:0] wa;
    logic [7:0] rd;
    logic [7:0] last = 8'h00;
    int wr_cnt = 0;
    function automatic logic prot(input logic [17:0] a);
        return a[17:13] == PROT_SECT && !i_reset_hv;
    endfunction
    initial for (int i = 0; i < 262144; i++) mem[i] = 8'hFF;
    always @(negedge i_we_n) if (!i_ce_n) wa = i_addr;
    // one decoder step per completed write strobe
    always @(posedge i_we_n) if (!i_ce_n && i_oe_n) begin
        wr_cnt++;
        chip = wa[10:0] == 11'h555 && i_dq == 8'h10;
        if (erasing && (i_dq == 8'hB0 || i_dq == 8'h30)) begin
            st = 3'h0;
        end else if (i_dq == 8'hF0 && st != 3'h3) begin
            st = 3'h0;
            ident = 1'h0;
            erasing = 1'h0;
        end else begin
            // low eleven bits only in unlock cycles any mismatch aborts
            case (st)
                3'h0, 3'h4: st = wa[10:0] == 11'h555 && i_dq == 8'hAA ? st + 3'h1 : 3'h0;
                3'h1, 3'h5: st = wa[10:0] == 11'h2AA && i_dq == 8'h55 ? st + 3'h1 : 3'h0;
                3'h2: begin
                    ident = wa[10:0] == 11'h555 && i_dq == 8'h90;
                    st = wa[10:0] != 11'h555 ? 3'h0 : i_dq == 8'hA0 ? 3'h3 :
                        i_dq == 8'h80 ? 3'h4 : 3'h0;
                end
                3'h3: begin
                    if (!prot(wa)) mem[wa] = mem[wa] & i_dq;
                    st = 3'h0;
                end
                3'h6: begin
                    erasing = i_dq == 8'h30;
                    for (int i = 0; i < 262144; i++)
                        if ((chip || erasing && 18'(i) >> 13 == 18'(wa[17:13])) && !prot(18'(i)))
                            mem[i] = 8'hFF;
                    st = 3'h0;
                end
                default: st = 3'h0;
            endcase
        end
    end
    assign rd = !ident ? mem[i_addr] : i_addr[12:0] == 13'h0000 ? MFR_CODE :
        i_addr[12:0] == 13'h0001 ? DEV_CODE :
        {7'h00, i_addr[12:0] == 13'h0002 && i_addr[17:13] == PROT_SECT};
    // released bus shows the inverse of the last byte driven
    assign o_dq = !i_ce_n && !i_oe_n ? rd : ~last;
    always @(posedge i_oe_n) last = rd;
endmodule

//--- dv/tb_flash_command_decoder.sv
// self-checking bench of the flash command host against a device model
`timescale 1ns/1ps
module tb_flash_command_decoder;
    logic i_clk = 1'h0;
    logic i_reset_n = 1'h0;
    logic i_req = 1'h0;
    logic [3:0] i_op = 4'h0;
    logic [17:0] i_addr = 18'h00000;
    logic [7:0] i_data = 8'h00;
    logic o_ready, o_done, o_parity_ok, o_in_ident, o_erasing, o_flash_dq_oe;
    logic o_flash_ce_n, o_flash_we_n, o_flash_oe_n, o_flash_reset_hv;
    logic [7:0] o_rdata, o_flash_dq_out, mdq, dq, d;
    logic [17:0] o_flash_addr, a;
    logic [31:0] lfsr = 32'h0000004E;
    int mismatches = 0;
    int checks_done = 0;
    assign dq = o_flash_dq_oe ? o_flash_dq_out : mdq;
    fcd_host uut (.i_clk, .i_reset_n, .i_req, .i_op, .i_addr, .i_data, .o_ready, .o_done,
        .o_rdata, .o_parity_ok, .o_in_ident, .o_erasing, .o_flash_addr, .o_flash_dq_out,
        .o_flash_dq_oe, .i_flash_dq_in(dq), .o_flash_ce_n, .o_flash_we_n, .o_flash_oe_n,
        .o_flash_reset_hv);
    fcd_flash_model u_flash (.i_addr(o_flash_addr), .i_dq(dq), .i_ce_n(o_flash_ce_n),
        .i_we_n(o_flash_we_n), .i_oe_n(o_flash_oe_n), .i_reset_hv(o_flash_reset_hv), .o_dq(mdq));
    initial forever #2.5 i_clk = ~i_clk;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], 1'h0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one user request; nw is the number of device writes it should cost
    task automatic run(input logic [3:0] op, input logic [17:0] ad, input logic [7:0] dt, int nw);
        int n;
        int w0;
        n = 0;
        while (o_ready !== 1'h1 && n < 400) begin
            @(negedge i_clk);
            n++;
        end
        w0 = u_flash.wr_cnt;
        i_req = 1'h1;
        i_op = op;
        i_addr = ad;
        i_data = dt;
        @(negedge i_clk);
        i_req = 1'h0;
        n = 0;
        while (o_done !== 1'h1 && n < 400) begin
            @(negedge i_clk);
            n++;
        end
        chk("done", 1, 32'(o_done));
        chk("writes", nw, 32'(u_flash.wr_cnt - w0));
    endtask
    task automatic rdc(input logic [3:0] op, input logic [17:0] ad, input logic [7:0] exp);
        run(op, ad, 8'h00, 0);
        chk("rdata", 32'(exp), 32'(o_rdata));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        conclude();
    end
    initial begin
        repeat (16) @(negedge i_clk);
        i_reset_n = 1'h1;
        rdc(fcd_pkg::OP_READ, 18'h00123, 8'hFF);
        for (int k = 0; k < 6; k++) begin
            lfsr = nxt(lfsr);
            a = {1'h1, lfsr[16:0]};
            d = lfsr[7:0];
            run(fcd_pkg::OP_PROG, a, d, 4);
            rdc(fcd_pkg::OP_READ, a, d);
        end
        run(fcd_pkg::OP_IDENT, 18'h3F000, 8'h00, 3);
        chk("ident", 1, 32'(o_in_ident));
        rdc(fcd_pkg::OP_READ_ID, 18'h00000, 8'h01);
        chk("parity", 1, 32'(o_parity_ok));
        rdc(fcd_pkg::OP_READ_ID, 18'h00001, 8'h07);
        rdc(fcd_pkg::OP_READ_PROT, 18'h06000, 8'h01);
        rdc(fcd_pkg::OP_READ_PROT, 18'h20000, 8'h00);
        chk("parity", 0, 32'(o_parity_ok));
        run(fcd_pkg::OP_IDENT, 18'h00000, 8'h00, 0);
        run(fcd_pkg::OP_RESET3, 18'h00000, 8'h00, 3);
        chk("ident", 0, 32'(o_in_ident));
        run(fcd_pkg::OP_READ_ID, 18'h00000, 8'h00, 0);
        run(4'hD, 18'h00000, 8'h00, 0);
        rdc(fcd_pkg::OP_READ, a, d);
        run(fcd_pkg::OP_PROG, 18'h06010, 8'h3C, 4);
        rdc(fcd_pkg::OP_READ, 18'h06010, 8'hFF);
        run(fcd_pkg::OP_HV_ON, 18'h00000, 8'h00, 0);
        run(fcd_pkg::OP_PROG, 18'h06010, 8'h3C, 4);
        run(fcd_pkg::OP_HV_OFF, 18'h00000, 8'h00, 0);
        run(fcd_pkg::OP_PROG, 18'h06020, 8'h3C, 4);
        rdc(fcd_pkg::OP_READ, 18'h06010, 8'h3C);
        rdc(fcd_pkg::OP_READ, 18'h06020, 8'hFF);
        run(fcd_pkg::OP_SUSPEND, 18'h00000, 8'h00, 0);
        run(fcd_pkg::OP_SECTOR_ERASE, a, 8'h00, 6);
        chk("erasing", 1, 32'(o_erasing));
        run(fcd_pkg::OP_SUSPEND, 18'h12345, 8'h00, 1);
        run(fcd_pkg::OP_RESUME, 18'h00007, 8'h00, 1);
        run(fcd_pkg::OP_RESET1, 18'h2C0DE, 8'h00, 1);
        chk("erasing", 0, 32'(o_erasing));
        rdc(fcd_pkg::OP_READ, a, 8'hFF);
        run(fcd_pkg::OP_PROG, 18'h20005, 8'h5A, 4);
        run(fcd_pkg::OP_CHIP_ERASE, 18'h00000, 8'h00, 6);
        rdc(fcd_pkg::OP_READ, 18'h20005, 8'hFF);
        rdc(fcd_pkg::OP_READ, 18'h06010, 8'h3C);
        conclude();
    end
endmodule
